//--- verilog/acc_regs.sv
// APB register page for codec format, input gain loop and playback volume.
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
`include "acc_cfg.svh"

// Function
// - Two-bit record high-pass select: off, or corner 0.0045, 0.0125, 0.025 Fs.
// - Word size field selects 16, 20, 24 or 32 bits; reset is 16.
// - Framing field selects I2S, DSP, right- or left-justified; reset is I2S.
// - Playback rate divider codes select reference divided by 1 to 6.
// - Record rate divider uses the same divider set.
// - Headset input mute silences the input; it resets set.
// - Headset gain runs 0 to 63.5 dB in half-dB steps; reset is maximum.
// - With the loop on, mute plus gain reads back the loop's applied gain.
// - That readback is a signed half-dB code from +59.5 to -12 dB.
// - Target field sets the loop's aimed output level, -5.5 to -24 dB.
// - Time constant field sets attack and decay, independent of sample rate.
// - Loop enable hands the amplifier from written fields to the loop; reset clear.
// - Left playback mute silences the left channel; it resets set.
// - Left attenuation runs 0 to -63.5 dB in half-dB steps; reset maximum.
// - Right playback mute silences the right channel; it resets set.
// - Right attenuation runs 0 to -63.5 dB in half-dB steps; reset maximum.
module acc_regs import acc_pkg::*; #(
  parameter int MS_CYCLES = `ACC_MS_CYCLES
) (
  // Clock and reset.
  input wire logic CLOCK_I,
  input wire logic RST_I,
  // APB slave.
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // Measured record level for the gain loop, signed half-dB.
  input wire logic LEVEL_VALID_I,
  input wire logic [7:0] LEVEL_I,
  // Record path and serial format controls.
  output logic [1:0] RECORD_HIGHPASS_SELECT_O,
  output logic [1:0] SERIAL_WORD_SIZE_O,
  output logic [5:0] SERIAL_WORD_BITS_O,
  output logic [1:0] SERIAL_FRAMING_FORMAT_O,
  output logic [2:0] PLAYBACK_RATE_DIVIDER_O,
  output logic [3:0] PLAYBACK_HALF_DIVIDER_O,
  output logic [2:0] RECORD_RATE_DIVIDER_O,
  output logic [3:0] RECORD_HALF_DIVIDER_O,
  // Headset/aux input amplifier.
  output logic HEADSET_AMP_MUTE_O,
  output logic [7:0] HEADSET_AMP_GAIN_O,
  output logic HEADSET_LOOP_ENABLE_O,
  // Playback channels.
  output logic LEFT_PLAYBACK_MUTE_O,
  output logic [6:0] LEFT_PLAYBACK_ATTENUATION_O,
  output logic RIGHT_PLAYBACK_MUTE_O,
  output logic [6:0] RIGHT_PLAYBACK_ATTENUATION_O
);
  logic [15:0] format_reg, format_next;
  logic [15:0] gain_reg, gain_next;
  logic [15:0] volume_reg, volume_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic [5:0] word_bits_reg, word_bits_next;
  logic [3:0] pdiv_reg, pdiv_next;
  logic [3:0] rdiv_reg, rdiv_next;
  logic amp_mute_reg, amp_mute_next;
  logic [7:0] amp_gain_reg, amp_gain_next;
  logic [7:0] loop_gain;
  logic [7:0] written_gain;
  logic loop_en;
  logic access;
  logic done;
  logic aligned;
  logic hit_format;
  logic hit_gain;
  logic hit_volume;
  logic mapped;
  logic [15:0] wdata;
  logic [15:0] rd_gain;

  assign loop_en = gain_reg[`ACC_LOOP_EN_BIT];
  assign written_gain = {1'b0, gain_reg[`ACC_HGAIN_MSB:`ACC_HGAIN_LSB]};

  // The answer comes one cycle into the access phase; the slave then releases it.
  assign access = PSEL_I && PENABLE_I && !pready_reg;
  assign done = PSEL_I && PENABLE_I && pready_reg;
  assign aligned = (PADDR_I[1:0] == 2'h0);
  assign hit_format = aligned && (PADDR_I[7:2] == `ACC_IDX_FORMAT);
  assign hit_gain = aligned && (PADDR_I[7:2] == `ACC_IDX_GAIN);
  assign hit_volume = aligned && (PADDR_I[7:2] == `ACC_IDX_VOLUME);
  assign mapped = hit_format || hit_gain || hit_volume;
  assign wdata = PWDATA_I[15:0];

  // With the loop on, the mute and gain positions carry the applied loop gain.
  always_comb begin
    rd_gain = gain_reg;
    if (loop_en) begin
      rd_gain[15:8] = loop_gain;
    end
  end

  acc_loop #(
    .MS_CYCLES(MS_CYCLES)
  ) u_loop (
    .clk_i(CLOCK_I),
    .rst_i(RST_I),
    .enable_i(loop_en),
    .start_gain_i(written_gain),
    .target_i(gain_reg[`ACC_TGT_MSB:`ACC_TGT_LSB]),
    .tc_i(gain_reg[`ACC_TC_MSB:`ACC_TC_LSB]),
    .level_valid_i(LEVEL_VALID_I),
    .level_i(LEVEL_I),
    .gain_o(loop_gain)
  );

  // Bus answer and register writes.
  always_comb begin
    prdata_next = prdata_reg;
    pready_next = 1'b0;
    pslverr_next = 1'b0;
    format_next = format_reg;
    gain_next = gain_reg;
    volume_next = volume_reg;
    if (access) begin
      pready_next = 1'b1;
      pslverr_next = !mapped;
      prdata_next = 32'h0;
      if (!PWRITE_I) begin
        if (hit_format) begin
          prdata_next = {16'h0, format_reg & `ACC_WMASK_FORMAT};
        end else if (hit_gain) begin
          prdata_next = {16'h0, rd_gain};
        end else if (hit_volume) begin
          prdata_next = {16'h0, volume_reg};
        end
      end
    end
    if (done && PWRITE_I) begin
      if (hit_format) begin
        format_next = wdata & `ACC_WMASK_FORMAT;
      end
      if (hit_gain) begin
        gain_next = wdata & `ACC_WMASK_GAIN;
      end
      if (hit_volume) begin
        volume_next = wdata & `ACC_WMASK_VOLUME;
      end
    end
  end

  // Derived controls: word size and dividers come from the next format value, the amplifier from the current gain register.
  always_comb begin
    word_bits_next = acc_word_bits(format_next[`ACC_WSZ_MSB:`ACC_WSZ_LSB]);
    pdiv_next = acc_half_div(format_next[`ACC_PDIV_MSB:`ACC_PDIV_LSB]);
    rdiv_next = acc_half_div(format_next[`ACC_RDIV_MSB:`ACC_RDIV_LSB]);
    if (gain_reg[`ACC_LOOP_EN_BIT]) begin
      amp_mute_next = 1'b0;
      amp_gain_next = loop_gain;
    end else begin
      amp_mute_next = gain_reg[`ACC_HMUTE_BIT];
      amp_gain_next = written_gain;
    end
  end

  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      format_reg <= `ACC_RST_FORMAT;
      gain_reg <= `ACC_RST_GAIN;
      volume_reg <= `ACC_RST_VOLUME;
      prdata_reg <= 32'h0;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      word_bits_reg <= `ACC_WORD_16;
      pdiv_reg <= `ACC_HDIV_0;
      rdiv_reg <= `ACC_HDIV_0;
      amp_mute_reg <= 1'b1;
      amp_gain_reg <= 8'h7f;
    end else begin
      format_reg <= format_next;
      gain_reg <= gain_next;
      volume_reg <= volume_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      word_bits_reg <= word_bits_next;
      pdiv_reg <= pdiv_next;
      rdiv_reg <= rdiv_next;
      amp_mute_reg <= amp_mute_next;
      amp_gain_reg <= amp_gain_next;
    end
  end

  assign PRDATA_O = prdata_reg;
  assign PREADY_O = pready_reg;
  assign PSLVERR_O = pslverr_reg;
  assign RECORD_HIGHPASS_SELECT_O = format_reg[`ACC_HPF_MSB:`ACC_HPF_LSB];
  assign SERIAL_WORD_SIZE_O = format_reg[`ACC_WSZ_MSB:`ACC_WSZ_LSB];
  assign SERIAL_WORD_BITS_O = word_bits_reg;
  assign SERIAL_FRAMING_FORMAT_O = format_reg[`ACC_FRM_MSB:`ACC_FRM_LSB];
  assign PLAYBACK_RATE_DIVIDER_O = format_reg[`ACC_PDIV_MSB:`ACC_PDIV_LSB];
  assign PLAYBACK_HALF_DIVIDER_O = pdiv_reg;
  assign RECORD_RATE_DIVIDER_O = format_reg[`ACC_RDIV_MSB:`ACC_RDIV_LSB];
  assign RECORD_HALF_DIVIDER_O = rdiv_reg;
  assign HEADSET_AMP_MUTE_O = amp_mute_reg;
  assign HEADSET_AMP_GAIN_O = amp_gain_reg;
  assign HEADSET_LOOP_ENABLE_O = gain_reg[`ACC_LOOP_EN_BIT];
  assign LEFT_PLAYBACK_MUTE_O = volume_reg[`ACC_LMUTE_BIT];
  assign LEFT_PLAYBACK_ATTENUATION_O = volume_reg[`ACC_LATT_MSB:`ACC_LATT_LSB];
  assign RIGHT_PLAYBACK_MUTE_O = volume_reg[`ACC_RMUTE_BIT];
  assign RIGHT_PLAYBACK_ATTENUATION_O = volume_reg[`ACC_RATT_MSB:`ACC_RATT_LSB];

  property p_word_bits;
    @(posedge CLOCK_I) disable iff (RST_I)
    SERIAL_WORD_SIZE_O == 2'h1 |-> SERIAL_WORD_BITS_O == 6'h14;
  endproperty
  a_word_bits: assert property (p_word_bits) else $error("Word size decode wrong.");

  property p_play_div;
    @(posedge CLOCK_I) disable iff (RST_I)
    PLAYBACK_RATE_DIVIDER_O == 3'h6 |-> PLAYBACK_HALF_DIVIDER_O == 4'hb;
  endproperty
  a_play_div: assert property (p_play_div) else $error("Playback divider wrong.");

  property p_rec_div;
    @(posedge CLOCK_I) disable iff (RST_I)
    RECORD_RATE_DIVIDER_O == 3'h1 |-> RECORD_HALF_DIVIDER_O == 4'h3;
  endproperty
  a_rec_div: assert property (p_rec_div) else $error("Record divider wrong.");

  property p_manual_amp;
    @(posedge CLOCK_I) disable iff (RST_I)
    !HEADSET_LOOP_ENABLE_O && $past(!HEADSET_LOOP_ENABLE_O) |=>
      HEADSET_AMP_MUTE_O == $past(gain_reg[15]) && HEADSET_AMP_GAIN_O == $past(written_gain);
  endproperty
  a_manual_amp: assert property (p_manual_amp) else $error("Amp not under fields.");

  property p_loop_read;
    @(posedge CLOCK_I) disable iff (RST_I)
    access && !PWRITE_I && hit_gain && loop_en |=> PRDATA_O[15:8] == $past(loop_gain);
  endproperty
  a_loop_read: assert property (p_loop_read) else $error("Loop gain not read back.");

  property p_reserved_zero;
    @(posedge CLOCK_I) disable iff (RST_I)
    access && !PWRITE_I && hit_format |=>
      PRDATA_O[13:12] == 2'h0 && PRDATA_O[7:6] == 2'h0 && PRDATA_O[31:16] == 16'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("Reserved bits set.");

  property p_left_mute;
    @(posedge CLOCK_I) disable iff (RST_I)
    done && PWRITE_I && hit_volume |=> LEFT_PLAYBACK_MUTE_O == $past(PWDATA_I[15]);
  endproperty
  a_left_mute: assert property (p_left_mute) else $error("Left mute not written.");

  property p_right_mute;
    @(posedge CLOCK_I) disable iff (RST_I)
    done && PWRITE_I && hit_volume |=>
      RIGHT_PLAYBACK_MUTE_O == $past(PWDATA_I[7]) &&
      RIGHT_PLAYBACK_ATTENUATION_O == $past(PWDATA_I[6:0]);
  endproperty
  a_right_mute: assert property (p_right_mute) else $error("Right channel not written.");

  property p_ready_pulse;
    @(posedge CLOCK_I) disable iff (RST_I)
    PREADY_O |=> !PREADY_O;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("Ready held too long.");

  property p_ready_answer;
    @(posedge CLOCK_I) disable iff (RST_I)
    access |=> PREADY_O;
  endproperty
  a_ready_answer: assert property (p_ready_answer) else $error("No answer after one wait.");

  property p_bad_addr;
    @(posedge CLOCK_I) disable iff (RST_I)
    access && !mapped |=> PSLVERR_O && PRDATA_O == 32'h0;
  endproperty
  a_bad_addr: assert property (p_bad_addr) else $error("Unmapped access not refused.");

  property p_hpf_write;
    @(posedge CLOCK_I) disable iff (RST_I)
    done && PWRITE_I && hit_format |=> RECORD_HIGHPASS_SELECT_O == $past(PWDATA_I[15:14]);
  endproperty
  a_hpf_write: assert property (p_hpf_write) else $error("Highpass not written.");

  property p_word_write;
    @(posedge CLOCK_I) disable iff (RST_I)
    done && PWRITE_I && hit_format |=> SERIAL_WORD_SIZE_O == $past(PWDATA_I[11:10]);
  endproperty
  a_word_write: assert property (p_word_write) else $error("Word size not written.");

  property p_word_max;
    @(posedge CLOCK_I) disable iff (RST_I)
    SERIAL_WORD_SIZE_O == 2'h3 |-> SERIAL_WORD_BITS_O == 6'h20;
  endproperty
  a_word_max: assert property (p_word_max) else $error("Long word decode wrong.");

  property p_framing_write;
    @(posedge CLOCK_I) disable iff (RST_I)
    done && PWRITE_I && hit_format |=> SERIAL_FRAMING_FORMAT_O == $past(PWDATA_I[9:8]);
  endproperty
  a_framing_write: assert property (p_framing_write) else $error("Framing not written.");

  property p_play_div_low;
    @(posedge CLOCK_I) disable iff (RST_I)
    PLAYBACK_RATE_DIVIDER_O == 3'h1 |-> PLAYBACK_HALF_DIVIDER_O == 4'h3;
  endproperty
  a_play_div_low: assert property (p_play_div_low) else $error("Playback divider wrong.");

  property p_rec_div_high;
    @(posedge CLOCK_I) disable iff (RST_I)
    RECORD_RATE_DIVIDER_O == 3'h7 |-> RECORD_HALF_DIVIDER_O == 4'hc;
  endproperty
  a_rec_div_high: assert property (p_rec_div_high) else $error("Record divider wrong.");

  property p_loop_en_write;
    @(posedge CLOCK_I) disable iff (RST_I)
    done && PWRITE_I && hit_gain |=> HEADSET_LOOP_ENABLE_O == $past(PWDATA_I[0]);
  endproperty
  a_loop_en_write: assert property (p_loop_en_write) else $error("Loop enable not written.");

  property p_loop_unmute;
    @(posedge CLOCK_I) disable iff (RST_I)
    HEADSET_LOOP_ENABLE_O |=> !HEADSET_AMP_MUTE_O;
  endproperty
  a_loop_unmute: assert property (p_loop_unmute) else $error("Amp muted under loop.");

  property p_loop_amp;
    @(posedge CLOCK_I) disable iff (RST_I)
    HEADSET_LOOP_ENABLE_O |=> HEADSET_AMP_GAIN_O == $past(loop_gain);
  endproperty
  a_loop_amp: assert property (p_loop_amp) else $error("Amp not under loop.");

  property p_left_att;
    @(posedge CLOCK_I) disable iff (RST_I)
    done && PWRITE_I && hit_volume |=> LEFT_PLAYBACK_ATTENUATION_O == $past(PWDATA_I[14:8]);
  endproperty
  a_left_att: assert property (p_left_att) else $error("Left volume not written.");
endmodule

//--- verilog/acc_cfg.svh
// Register offsets, field positions, reset values and timing counts of the codec control page.
`ifndef ACC_CFG_SVH
`define ACC_CFG_SVH

// Register indices; the byte address is four times the index.
`define ACC_IDX_FORMAT 6'h00
`define ACC_IDX_GAIN 6'h01
`define ACC_IDX_VOLUME 6'h02

// Reset values and writable-bit masks.
`define ACC_RST_FORMAT 16'h0000
`define ACC_RST_GAIN 16'hff00
`define ACC_RST_VOLUME 16'hffff
`define ACC_WMASK_FORMAT 16'hcf3f
`define ACC_WMASK_GAIN 16'hffff
`define ACC_WMASK_VOLUME 16'hffff

// Field positions in the format/rate register.
`define ACC_HPF_MSB 15
`define ACC_HPF_LSB 14
`define ACC_WSZ_MSB 11
`define ACC_WSZ_LSB 10
`define ACC_FRM_MSB 9
`define ACC_FRM_LSB 8
`define ACC_PDIV_MSB 5
`define ACC_PDIV_LSB 3
`define ACC_RDIV_MSB 2
`define ACC_RDIV_LSB 0

// Field positions in the input gain register.
`define ACC_HMUTE_BIT 15
`define ACC_HGAIN_MSB 14
`define ACC_HGAIN_LSB 8
`define ACC_TGT_MSB 7
`define ACC_TGT_LSB 5
`define ACC_TC_MSB 4
`define ACC_TC_LSB 1
`define ACC_LOOP_EN_BIT 0

// Field positions in the playback volume register.
`define ACC_LMUTE_BIT 15
`define ACC_LATT_MSB 14
`define ACC_LATT_LSB 8
`define ACC_RMUTE_BIT 7
`define ACC_RATT_MSB 6
`define ACC_RATT_LSB 0

// Serial word sizes in bits.
`define ACC_WORD_16 6'h10
`define ACC_WORD_20 6'h14
`define ACC_WORD_24 6'h18
`define ACC_WORD_32 6'h20

// Rate dividers expressed in half steps (divider times two).
`define ACC_HDIV_0 4'h2
`define ACC_HDIV_1 4'h3
`define ACC_HDIV_2 4'h4
`define ACC_HDIV_3 4'h6
`define ACC_HDIV_4 4'h8
`define ACC_HDIV_5 4'ha
`define ACC_HDIV_6 4'hb
`define ACC_HDIV_7 4'hc

// Loop targets in signed half-dB steps.
`define ACC_TGT_0 8'hf5
`define ACC_TGT_1 8'hf0
`define ACC_TGT_2 8'hec
`define ACC_TGT_3 8'he8
`define ACC_TGT_4 8'he4
`define ACC_TGT_5 8'hde
`define ACC_TGT_6 8'hd8
`define ACC_TGT_7 8'hd0

// Loop gain limits in signed half-dB steps.
`define ACC_GAIN_MIN 8'he8
`define ACC_GAIN_MAX 8'h77

// Attack and decay times in milliseconds.
`define ACC_ATK_0_MS 9'h008
`define ACC_ATK_1_MS 9'h00b
`define ACC_ATK_2_MS 9'h010
`define ACC_ATK_3_MS 9'h014
`define ACC_DCY_0_MS 9'h064
`define ACC_DCY_1_MS 9'h0c8
`define ACC_DCY_2_MS 9'h190
`define ACC_DCY_3_MS 9'h1f4

// Clock period and one millisecond, both in ns.
`define ACC_CLK_PERIOD_NS 5
`define ACC_MS_NS 1000000
`define ACC_MS_CYCLES (`ACC_MS_NS / `ACC_CLK_PERIOD_NS)

`endif

//--- verilog/acc_pkg.sv
// Types and decode helpers of the codec control page.
package acc_pkg;
`include "acc_cfg.svh"

  typedef enum logic [1:0] {
    ACC_FRM_I2S = 2'b00,
    ACC_FRM_DSP = 2'b01,
    ACC_FRM_RJ = 2'b10,
    ACC_FRM_LJ = 2'b11
  } acc_framing_t;

  typedef enum logic [1:0] {
    ACC_HPF_OFF = 2'b00,
    ACC_HPF_0045 = 2'b01,
    ACC_HPF_0125 = 2'b10,
    ACC_HPF_0250 = 2'b11
  } acc_hpf_t;

  function automatic logic [5:0] acc_word_bits(input logic [1:0] code);
    case (code)
      2'h0: acc_word_bits = `ACC_WORD_16;
      2'h1: acc_word_bits = `ACC_WORD_20;
      2'h2: acc_word_bits = `ACC_WORD_24;
      default: acc_word_bits = `ACC_WORD_32;
    endcase
  endfunction

  function automatic logic [3:0] acc_half_div(input logic [2:0] code);
    case (code)
      3'h0: acc_half_div = `ACC_HDIV_0;
      3'h1: acc_half_div = `ACC_HDIV_1;
      3'h2: acc_half_div = `ACC_HDIV_2;
      3'h3: acc_half_div = `ACC_HDIV_3;
      3'h4: acc_half_div = `ACC_HDIV_4;
      3'h5: acc_half_div = `ACC_HDIV_5;
      3'h6: acc_half_div = `ACC_HDIV_6;
      default: acc_half_div = `ACC_HDIV_7;
    endcase
  endfunction
endpackage

//--- verilog/acc_loop.sv
// Automatic gain loop for the headset/aux input amplifier.
`timescale 1ns/10ps
`include "acc_cfg.svh"
module acc_loop import acc_pkg::*; #(
  parameter int MS_CYCLES = `ACC_MS_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic enable_i,
  input wire logic [7:0] start_gain_i,
  input wire logic [2:0] target_i,
  input wire logic [3:0] tc_i,
  input wire logic level_valid_i,
  input wire logic [7:0] level_i,
  output logic [7:0] gain_o
);
  logic [31:0] tick_reg, tick_next;
  logic [8:0] ms_reg, ms_next;
  logic [7:0] gain_reg, gain_next;
  logic [7:0] level_reg, level_next;
  logic [7:0] target;
  logic [8:0] attack_ms;
  logic [8:0] decay_ms;
  logic ms_tick;

  assign gain_o = gain_reg;

  always_comb begin
    case (target_i)
      3'h0: target = `ACC_TGT_0;
      3'h1: target = `ACC_TGT_1;
      3'h2: target = `ACC_TGT_2;
      3'h3: target = `ACC_TGT_3;
      3'h4: target = `ACC_TGT_4;
      3'h5: target = `ACC_TGT_5;
      3'h6: target = `ACC_TGT_6;
      default: target = `ACC_TGT_7;
    endcase
    case (tc_i[1:0])
      2'h0: attack_ms = `ACC_ATK_0_MS;
      2'h1: attack_ms = `ACC_ATK_1_MS;
      2'h2: attack_ms = `ACC_ATK_2_MS;
      default: attack_ms = `ACC_ATK_3_MS;
    endcase
    case (tc_i[3:2])
      2'h0: decay_ms = `ACC_DCY_0_MS;
      2'h1: decay_ms = `ACC_DCY_1_MS;
      2'h2: decay_ms = `ACC_DCY_2_MS;
      default: decay_ms = `ACC_DCY_3_MS;
    endcase
  end

  // Steps are timed in milliseconds of the system clock, so the loop is rate independent.
  always_comb begin
    ms_tick = (tick_reg == 32'(MS_CYCLES - 1));
    tick_next = ms_tick ? 32'h0 : tick_reg + 32'h1;
    ms_next = ms_tick ? ms_reg + 9'h1 : ms_reg;
    gain_next = gain_reg;
    level_next = level_valid_i ? level_i : level_reg;
    if (!enable_i) begin
      tick_next = 32'h0;
      ms_next = 9'h0;
      // Written codes above +59.5 dB start the loop at its ceiling.
      gain_next = ($signed(start_gain_i) > $signed(`ACC_GAIN_MAX)) ? `ACC_GAIN_MAX : start_gain_i;
      level_next = target;
    end else if ($signed(level_reg) > $signed(target)) begin
      if (ms_reg >= attack_ms) begin
        ms_next = 9'h0;
        if ($signed(gain_reg) > $signed(`ACC_GAIN_MIN)) begin
          gain_next = gain_reg - 8'h1;
        end
      end
    end else if ($signed(level_reg) < $signed(target)) begin
      if (ms_reg >= decay_ms) begin
        ms_next = 9'h0;
        if ($signed(gain_reg) < $signed(`ACC_GAIN_MAX)) begin
          gain_next = gain_reg + 8'h1;
        end
      end
    end else begin
      ms_next = 9'h0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tick_reg <= 32'h0;
      ms_reg <= 9'h0;
      gain_reg <= `ACC_GAIN_MAX;
      level_reg <= 8'h0;
    end else begin
      tick_reg <= tick_next;
      ms_reg <= ms_next;
      gain_reg <= gain_next;
      level_reg <= level_next;
    end
  end

  property p_loop_range;
    @(posedge clk_i) disable iff (rst_i)
    enable_i && $past(enable_i) |->
      $signed(gain_reg) >= $signed(`ACC_GAIN_MIN) && $signed(gain_reg) <= $signed(`ACC_GAIN_MAX);
  endproperty
  a_loop_range: assert property (p_loop_range) else $error("Loop gain out of range.");

  property p_target_map;
    @(posedge clk_i) disable iff (rst_i)
    target_i == 3'h7 |-> target == 8'hd0;
  endproperty
  a_target_map: assert property (p_target_map) else $error("Target table wrong.");
endmodule

//--- test/tb_audio_codec_control_page_regs.sv
// Self-checking testbench for the codec control register page.
`timescale 1ns/10ps
`include "acc_cfg.svh"
module tb_audio_codec_control_page_regs import acc_pkg::*;;
  localparam logic [7:0] A_FMT = {`ACC_IDX_FORMAT, 2'b00};
  localparam logic [7:0] A_GAIN = {`ACC_IDX_GAIN, 2'b00};
  localparam logic [7:0] A_VOL = {`ACC_IDX_VOLUME, 2'b00};
  // Serial word sizes and rate dividers times two, by field code.
  localparam logic [5:0] WBITS [4] = '{6'h10, 6'h14, 6'h18, 6'h20};
  localparam logic [3:0] HDIV [8] = '{4'h2, 4'h3, 4'h4, 4'h6, 4'h8, 4'ha, 4'hb, 4'hc};

  logic clk = 1'b0;
  logic rst;
  logic psel, penable, pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr;
  logic level_valid;
  logic [7:0] level;
  logic [1:0] hpf, wsz, frm;
  logic [5:0] wbits;
  logic [2:0] pdiv, rdiv;
  logic [3:0] phalf, rhalf;
  logic amp_mute, loop_en, l_mute, r_mute;
  logic [7:0] amp_gain;
  logic [6:0] l_att, r_att;
  int n_errors = 0;
  int compares = 0;

  always #2.5 clk = ~clk;

  acc_regs #(.MS_CYCLES(10)) i_acc_regs (
    .CLOCK_I(clk), .RST_I(rst),
    .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
    .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .LEVEL_VALID_I(level_valid), .LEVEL_I(level),
    .RECORD_HIGHPASS_SELECT_O(hpf), .SERIAL_WORD_SIZE_O(wsz), .SERIAL_WORD_BITS_O(wbits),
    .SERIAL_FRAMING_FORMAT_O(frm), .PLAYBACK_RATE_DIVIDER_O(pdiv),
    .PLAYBACK_HALF_DIVIDER_O(phalf), .RECORD_RATE_DIVIDER_O(rdiv),
    .RECORD_HALF_DIVIDER_O(rhalf), .HEADSET_AMP_MUTE_O(amp_mute),
    .HEADSET_AMP_GAIN_O(amp_gain), .HEADSET_LOOP_ENABLE_O(loop_en),
    .LEFT_PLAYBACK_MUTE_O(l_mute), .LEFT_PLAYBACK_ATTENUATION_O(l_att),
    .RIGHT_PLAYBACK_MUTE_O(r_mute), .RIGHT_PLAYBACK_ATTENUATION_O(r_att)
  );

  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic timeout(input string what);
    n_errors++;
    $display("CHECK FAILED %s expected completion seen timeout", what);
    close_out();
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One APB transfer; ready, read data and error are taken at the rising edge.
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [15:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= {16'h0000, wd};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    @(posedge clk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 20) timeout("apb ready");
      @(posedge clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wreg(input logic [7:0] addr, input logic [15:0] wd, input logic exp_err);
    logic [31:0] rd;
    logic err;
    apb(1'b1, addr, wd, rd, err);
    chk("write error flag", exp_err, err);
  endtask

  task automatic rreg(input logic [7:0] addr, input logic [31:0] exp, input logic exp_err);
    logic [31:0] rd;
    logic err;
    apb(1'b0, addr, 16'h0000, rd, err);
    chk("read error flag", exp_err, err);
    chk("read data", exp, rd);
  endtask

  task automatic settle;
    repeat (3) @(posedge clk);
  endtask

  task automatic t_reset;
    rreg(A_FMT, 32'h0000, 1'b0);
    rreg(A_GAIN, 32'hff00, 1'b0);
    rreg(A_VOL, 32'hffff, 1'b0);
    chk("word bits", 6'h10, wbits);
    chk("framing", 2'b00, frm);
    chk("half dividers", 8'h22, {phalf, rhalf});
    chk("headset mute", 1'b1, amp_mute);
    chk("headset gain", 8'h7f, amp_gain);
    chk("loop enable", 1'b0, loop_en);
    chk("left playback", 8'hff, {l_mute, l_att});
    chk("right playback", 8'hff, {r_mute, r_att});
  endtask

  // Every divider code, and every word size, framing and filter code twice.
  // Right-justified frames only meet rate pairs in an integer ratio.
  task automatic t_format;
    logic [2:0] k;
    logic [15:0] wd;
    for (int i = 0; i < 8; i++) begin
      k = i[2:0];
      wd = {k[1:0], 2'b11, k[1:0], k[1], k[2], 2'b11, k, k ^ 3'h2};
      wreg(A_FMT, wd, 1'b0);
      settle();
      rreg(A_FMT, wd & 16'hcf3f, 1'b0);
      chk("highpass", k[1:0], hpf);
      chk("word size", k[1:0], wsz);
      chk("word bits", WBITS[k[1:0]], wbits);
      chk("framing", {k[1], k[2]}, frm);
      chk("playback divider", {k, HDIV[k]}, {pdiv, phalf});
      chk("record divider", {k ^ 3'h2, HDIV[k ^ 3'h2]}, {rdiv, rhalf});
    end
  endtask

  task automatic t_volume;
    wreg(A_VOL, 16'h0000, 1'b0);
    settle();
    chk("left playback", 8'h00, {l_mute, l_att});
    chk("right playback", 8'h00, {r_mute, r_att});
    wreg(A_VOL, 16'h7f80, 1'b0);
    settle();
    rreg(A_VOL, 32'h7f80, 1'b0);
    chk("left playback", 8'h7f, {l_mute, l_att});
    chk("right playback", 8'h80, {r_mute, r_att});
  endtask

  task automatic t_bus_error;
    rreg(8'h0c, 32'h0000, 1'b1);
    wreg(8'h05, 16'h1234, 1'b1);
    wreg(8'h0c, 16'h1234, 1'b1);
    rreg(A_GAIN, 32'hff00, 1'b0);
  endtask

  task automatic wait_gain(input logic [7:0] g, input int lim);
    int n;
    n = 0;
    while (amp_gain !== g) begin
      n++;
      if (n > lim) timeout("loop gain step");
      @(posedge clk);
    end
  endtask

  task automatic t_gain;
    wreg(A_GAIN, 16'h0a00, 1'b0);
    settle();
    chk("headset amp", 9'h00a, {amp_mute, amp_gain});
    wreg(A_GAIN, 16'h8a00, 1'b0);
    settle();
    chk("headset amp", 9'h10a, {amp_mute, amp_gain});
    // Level 0 dB stays above the -24 dB target, so the loop walks the gain down.
    level <= 8'h00;
    level_valid <= 1'b1;
    wreg(A_GAIN, 16'h8ae1, 1'b0);
    settle();
    chk("loop amp", 10'h20a, {loop_en, amp_mute, amp_gain});
    rreg(A_GAIN, 32'h0ae1, 1'b0);
    repeat (60) @(posedge clk);
    chk("loop attack hold", 8'h0a, amp_gain);
    wait_gain(8'h09, 100);
    chk("loop first step", 8'h09, amp_gain);
    wait_gain(8'he8, 5000);
    repeat (200) @(posedge clk);
    chk("loop floor", 8'he8, amp_gain);
    rreg(A_GAIN, 32'he8e1, 1'b0);
    // Far below target the loop raises the gain only after the decay time.
    level <= 8'h80;
    repeat (850) @(posedge clk);
    chk("loop decay hold", 8'he8, amp_gain);
    wait_gain(8'he9, 300);
    chk("loop rise", 8'he9, amp_gain);
    level_valid <= 1'b0;
    wreg(A_GAIN, 16'h0500, 1'b0);
    settle();
    chk("manual amp", 10'h005, {loop_en, amp_mute, amp_gain});
  endtask

  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    level_valid = 1'b0;
    level = 8'h00;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_format();
    t_volume();
    t_bus_error();
    t_gain();
    close_out();
  end
endmodule
